// ==== rtl/pca_pkg.sv ====
// package for the plot colour and address unit
// assumes a single coprocessor clock domain
package pca_pkg;
   // plot colour mode bit positions
   localparam int MODE_TRANSP_BIT = 0;
   localparam int MODE_DITHER_BIT = 1;
   localparam int MODE_HINIB_BIT = 2;
   localparam int MODE_FREEZE_BIT = 3;
   localparam int MODE_SPRITE_BIT = 4;
   localparam logic [4:0] MODE_RESET = 5'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] COORD_RESET = 8'h00;
   localparam logic [19:0] ADDR_RESET = 20'h0_0000;
   // character index multipliers per height
   localparam logic [4:0] MUL_128 = 5'h10;
   localparam logic [4:0] MUL_160 = 5'h14;
   localparam logic [4:0] MUL_192 = 5'h18;
   // screen base field position in the address
   localparam int BASE_LSB = 10;

   typedef enum logic [1:0] {
      PCA_DEPTH_4 = 2'b00,
      PCA_DEPTH_16 = 2'b01,
      PCA_DEPTH_256 = 2'b11
   } pca_depth_t;

   typedef enum logic [1:0] {
      PCA_HT_128 = 2'b00,
      PCA_HT_160 = 2'b01,
      PCA_HT_192 = 2'b10,
      PCA_HT_RSVD = 2'b11
   } pca_height_t;

   // one plot result as seen by the pixel cache
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] pixel_lo;
      logic [7:0] pixel;
      logic [9:0] char_index;
      logic [19:0] addr;
   } pca_plot_t;
endpackage

// ==== rtl/pca_plot_unit.sv ====
// plot colour mode, colour latch, coordinate and address logic
// assumes instruction decode drives one-cycle op strobes on mclk
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - transparency off and effective colour zero: plot only advances x, writes nothing.
// - transparency test uses 8 bits with freeze clear, 4 bits with freeze set.
// - dither picks latch low nibble when (x xor y) bit 0 is 0, else high.
// - dither acts only in 4 and 16 colour depths, never in 256.
// - transparency is decided from the undithered latch, independent of nibble choice.
// - high-nibble bit loads source upper four bits instead of lower four.
// - 256 colour with freeze set: load changes only latch low nibble.
// - sprite bit selects sprite layout, otherwise height-select bits choose layout.
// - x and y are the low bytes of the coordinate registers.
// - non-sprite index is x[7:3] times 10h/14h/18h plus y[7:3].
// - address built from index, depth, layout and screen base.
// - address: base from bit 10, y[2:0] at 3..1, plane0 at 0, index by depth.
// - every plot, suppressed or not, increments x by one.
module pca_plot_unit
   import pca_pkg::*;
#(
   // coordinate register width; addressing reads only the low byte
   parameter int COORD_W = 16
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // instruction strobes
   input wire logic mode_wr,
   input wire logic [4:0] mode_wdata,
   input wire logic colour_load,
   input wire logic [7:0] colour_src,
   input wire logic plot_op,
   input wire logic read_pixel_flush_op,
   input wire logic [2:0] bitplane_index,
   // coordinate register writes
   input wire logic x_wr,
   input wire logic [COORD_W-1:0] x_wdata,
   input wire logic y_wr,
   input wire logic [COORD_W-1:0] y_wdata,
   // screen setup
   input wire logic [1:0] colour_depth,
   input wire logic height_select_lo,
   input wire logic height_select_hi,
   input wire logic [7:0] screen_base_reg,
   // state and plot results
   output logic [4:0] plot_colour_mode,
   output logic [7:0] colour_latch,
   output logic [COORD_W-1:0] x_coord_reg,
   output logic [COORD_W-1:0] y_coord_reg,
   output pca_plot_t plot_out
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [9:0] char_idx(input logic [7:0] x, input logic [7:0] y,
                                           input logic sprite, input logic [1:0] ht);
      logic [4:0] mul;
      logic [9:0] prod;
      mul = MUL_128;
      prod = 10'h000;
      if (sprite) begin
         char_idx = {y[7], x[7], y[6:3], x[6:3]};
      end else begin
         unique case (ht)
            PCA_HT_128: mul = MUL_128;
            PCA_HT_160: mul = MUL_160;
            default: mul = MUL_192; // reserved code treated as tallest
         endcase
         prod = 10'({5'h00, x[7:3]} * {5'h00, mul});
         char_idx = prod + {5'h00, y[7:3]};
      end
   endfunction

   function automatic logic [19:0] plot_addr(input logic [9:0] cn, input logic [7:0] y,
                                             input logic [2:0] pl, input logic [1:0] depth,
                                             input logic [7:0] base);
      logic [19:0] a;
      a = 20'(base) << BASE_LSB;
      unique case (depth)
         PCA_DEPTH_4: a = a + {6'h00, cn, y[2:0], pl[0]};
         PCA_DEPTH_16: a = a + {5'h00, cn, pl[1], y[2:0], pl[0]};
         default: a = a + {4'h0, cn, pl[2:1], y[2:0], pl[0]};
      endcase
      plot_addr = a;
   endfunction

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // addressing reads the low byte, and the step wraps inside the register
   if (COORD_W < 8 || COORD_W > 32) begin : g_coord_w_check
      $error("pca_plot_unit: COORD_W must lie between 8 and 32");
   end

   // ----------------------------------------
   // constants
   // ----------------------------------------
   localparam logic [COORD_W-1:0] X_STEP = COORD_W'(1);
   localparam logic [COORD_W-1:0] COORD_ZERO = COORD_W'(COORD_RESET);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [4:0] mode_reg;
   logic [4:0] mode_next;
   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic [COORD_W-1:0] x_reg;
   logic [COORD_W-1:0] x_next;
   logic [COORD_W-1:0] y_reg;
   logic [COORD_W-1:0] y_next;
   pca_plot_t out_reg;
   pca_plot_t out_next;

   // ----------------------------------------
   // combinational helpers
   // ----------------------------------------
   logic transp;
   logic dither;
   logic hinib;
   logic freeze;
   logic sprite;
   logic is256;
   logic [1:0] ht;
   logic [3:0] load_nib;
   logic visible;
   logic [3:0] dith_nib;
   logic [7:0] pix;
   logic [9:0] cn;
   logic [19:0] addr;

   // ----------------------------------------
   // mode and screen decode
   // ----------------------------------------
   // the mode bits are used as stored; a write shows on the next plot
   // the reserved height code is resolved inside char_idx
   always_comb begin
      transp = mode_reg[MODE_TRANSP_BIT];
      dither = mode_reg[MODE_DITHER_BIT];
      hinib = mode_reg[MODE_HINIB_BIT];
      freeze = mode_reg[MODE_FREEZE_BIT];
      sprite = mode_reg[MODE_SPRITE_BIT];
      is256 = (colour_depth == PCA_DEPTH_256);
      ht = {height_select_hi, height_select_lo};
   end

   // ----------------------------------------
   // mode register
   // ----------------------------------------
   // changing the sprite bit with pixels still cached would file them
   // under the new layout; keeping that safe is up to the program
   always_comb begin
      mode_next = mode_reg;
      if (mode_wr) begin
         mode_next = mode_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_reg <= MODE_RESET;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ----------------------------------------
   // colour latch
   // ----------------------------------------
   // one load path serves both the register source and the rom buffer
   always_comb begin
      load_nib = colour_src[3:0];
      if (hinib) begin
         load_nib = colour_src[7:4];
      end
      latch_next = latch_reg;
      if (colour_load) begin
         if (is256 && freeze) begin
            // the held upper nibble works as a palette select
            latch_next = {latch_reg[7:4], load_nib};
         end else if (hinib) begin
            latch_next = {4'h0, load_nib};
         end else begin
            // with neither the freeze case nor the high-nibble bit in force, a load replaces the whole byte
            latch_next = colour_src;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         latch_reg <= LATCH_RESET;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ----------------------------------------
   // pixel value and transparency
   // ----------------------------------------
   // transparency is judged on the undithered latch, in parallel with
   // the pixel path; a dither pair of clear and visible colours cannot work
   always_comb begin
      if (freeze) begin
         visible = (latch_reg[3:0] != 4'h0);
      end else begin
         visible = (latch_reg != 8'h00);
      end
      dith_nib = latch_reg[3:0];
      if (x_reg[0] ^ y_reg[0]) begin
         dith_nib = latch_reg[7:4];
      end
      // 256 colour pixels are whole bytes, so the dither bit is ignored there
      pix = latch_reg;
      if (dither && !is256) begin
         pix = {4'h0, dith_nib};
      end
   end

   // ----------------------------------------
   // character index and byte address
   // ----------------------------------------
   // only the low bytes of the coordinates take part in addressing
   always_comb begin
      cn = char_idx(x_reg[7:0], y_reg[7:0], sprite, ht);
      addr = plot_addr(cn, y_reg[7:0], bitplane_index, colour_depth, screen_base_reg);
   end

   // ----------------------------------------
   // coordinates
   // ----------------------------------------
   // a plot wins over an x write in the same cycle, so runs of plots
   // to the right need no coordinate reloads
   always_comb begin
      x_next = x_reg;
      if (x_wr) begin
         x_next = x_wdata;
      end
      if (plot_op) begin
         x_next = x_reg + X_STEP;
      end
      // y only ever changes by a write
      y_next = y_reg;
      if (y_wr) begin
         y_next = y_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         x_reg <= COORD_ZERO;
         y_reg <= COORD_ZERO;
      end else begin
         x_reg <= x_next;
         y_reg <= y_next;
      end
   end

   // ----------------------------------------
   // plot result
   // ----------------------------------------
   // valid and write pulse for one cycle; the data fields hold until the
   // next plot or flush so the pixel cache may take them late
   always_comb begin
      out_next = out_reg;
      out_next.valid = 1'b0;
      out_next.write = 1'b0;
      if (plot_op || read_pixel_flush_op) begin
         out_next.valid = 1'b1;
         // a suppressed plot still steps x but stores nothing
         out_next.write = plot_op && (transp || visible);
         out_next.pixel = pix;
         out_next.pixel_lo = pix[3:0];
         out_next.char_index = cn;
         out_next.addr = addr;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         // reset clears the pulses and the held data alike
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // every output is a register, never a combinational path
   assign plot_colour_mode = mode_reg;
   assign colour_latch = latch_reg;
   assign x_coord_reg = x_reg;
   assign y_coord_reg = y_reg;
   assign plot_out = out_reg;

endmodule
`default_nettype wire

// ==== sim/pca_plot_unit_assertions.sv ====
// port checker for the plot unit
// assumes the bind below attaches it
`timescale 1ns/100ps
`default_nettype none
module pca_plot_unit_checker
   import pca_pkg::*;
(
   // watched ports
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic plot_op,
   input wire logic colour_load,
   input wire logic [7:0] colour_src,
   input wire logic [2:0] bitplane_index,
   input wire logic [1:0] colour_depth,
   input wire logic [4:0] plot_colour_mode,
   input wire logic [7:0] colour_latch,
   input wire logic [15:0] x_coord_reg,
   input wire logic [15:0] y_coord_reg,
   input wire pca_plot_t plot_out
);
   logic d256;
   logic zc;
   assign d256 = colour_depth == 2'h3;
   // freeze narrows the transparency test to the low nibble
   assign zc = plot_colour_mode[3] ? colour_latch[3:0] == 4'h0 : colour_latch == 8'h00;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_X_STEP: assert property (plot_op |=> x_coord_reg == $past(x_coord_reg) + 16'h0001)
      else $error("x not stepped");
   AST_HIDE: assert property (plot_op && !plot_colour_mode[0] && zc |=> plot_out.valid && !plot_out.write)
      else $error("zero colour written");
   AST_SHOW: assert property (plot_op && !zc |=> plot_out.write)
      else $error("visible colour dropped");
   AST_DITHER: assert property (plot_op && plot_colour_mode[1] && !d256 |=> plot_out.pixel == {4'h0,
      ($past(x_coord_reg[0]) ^ $past(y_coord_reg[0])) ?
      $past(colour_latch[7:4]) : $past(colour_latch[3:0])})
      else $error("dither nibble wrong");
   AST_FULL: assert property (plot_op && d256 && plot_colour_mode[0] |=> plot_out.pixel == $past(colour_latch))
      else $error("full colour wrong");
   AST_HINIB: assert property (colour_load && plot_colour_mode[2] && !(plot_colour_mode[3] && d256)
      |=> colour_latch == {4'h0, $past(colour_src[7:4])})
      else $error("high nibble load wrong");
   AST_FREEZE: assert property (colour_load && plot_colour_mode[3] && d256 |=> $stable(colour_latch[7:4]))
      else $error("frozen nibble changed");
   AST_SPRITE: assert property (plot_op && plot_colour_mode[4] |=>
      plot_out.char_index == {$past(y_coord_reg[7]), $past(x_coord_reg[7]),
      $past(y_coord_reg[6:3]), $past(x_coord_reg[6:3])})
      else $error("sprite index wrong");
   AST_LOW_ADDR: assert property (plot_op |=>
      plot_out.addr[3:0] == {$past(y_coord_reg[2:0]), $past(bitplane_index[0])})
      else $error("low address wrong");
endmodule
bind pca_plot_unit pca_plot_unit_checker pca_plot_unit_checker_i (.mclk, .rst_n, .plot_op, .colour_load,
   .colour_src, .bitplane_index, .colour_depth, .plot_colour_mode, .colour_latch, .x_coord_reg, .y_coord_reg,
   .plot_out);
`default_nettype wire

// ==== sim/pca_cart_ram.sv ====
// cartridge ram model holding character bytes
// assumes plot_out comes straight from the plot unit
`timescale 1ns/100ps
`default_nettype none
module pca_cart_ram
   import pca_pkg::*;
(
   // plot side and bench read side
   input wire logic mclk,
   input wire pca_plot_t plot_out,
   input wire logic [19:0] rd_addr,
   output logic [7:0] rd_data
);
   // unwritten bytes stay unknown so a wrong address cannot match
   logic [7:0] mem [0:1048575];
   assign rd_data = mem[rd_addr];
   always_ff @(posedge mclk) begin
      if (plot_out.valid && plot_out.write)
         mem[plot_out.addr] <= plot_out.pixel;
   end
endmodule
`default_nettype wire

// ==== sim/plot_colour_and_address_unit_tb_top.sv ====
// random bench for the plot unit and ram model
// assumes the checker binds itself to the unit
`timescale 1ns/100ps
`default_nettype none
module plot_colour_and_address_unit_tb_top;
   import pca_pkg::*;
   logic mclk, rst_n, mode_wr, colour_load, plot_op, read_pixel_flush_op, x_wr, y_wr;
   logic height_select_lo, height_select_hi;
   logic [4:0] mode_wdata, plot_colour_mode, md;
   logic [7:0] colour_src, screen_base_reg, colour_latch, rd_data, lat, px;
   logic [2:0] bitplane_index;
   logic [1:0] colour_depth, d;
   logic [15:0] x_wdata, y_wdata, x_coord_reg, y_coord_reg;
   logic [19:0] rd_addr, ea;
   logic [31:0] rs;
   logic wr;
   pca_plot_t plot_out;
   int n_fail, n_checks;
   pca_plot_unit pca_plot_unit_i (.mclk, .rst_n, .mode_wr, .mode_wdata, .colour_load, .colour_src, .plot_op,
      .read_pixel_flush_op, .bitplane_index, .x_wr, .x_wdata, .y_wr, .y_wdata, .colour_depth, .height_select_lo,
      .height_select_hi, .screen_base_reg, .plot_colour_mode, .colour_latch, .x_coord_reg, .y_coord_reg, .plot_out);
   pca_cart_ram pca_cart_ram_i (.mclk, .plot_out, .rd_addr, .rd_data);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic logic [9:0] f_cn(input logic [7:0] x, y, input logic sp, input logic [1:0] h);
      if (sp)
         return {y[7], x[7], y[6:3], x[6:3]};
      return 10'(x[7:3]) * (h[1] ? 10'h018 : h[0] ? 10'h014 : 10'h010) + 10'(y[7:3]);
   endfunction
   function automatic logic [19:0] f_ad(input logic [9:0] c, input logic [2:0] y, p, input logic [1:0] g);
      logic [19:0] a;
      a = {2'h0, screen_base_reg, 10'h000} + {16'h0000, y, p[0]};
      case (g)
         2'h0: a += 20'(c) << 4;
         2'h1: a += (20'(c) << 5) + 20'({p[1], 4'h0});
         default: a += (20'(c) << 6) + 20'({p[2:1], 4'h0});
      endcase
      return a;
   endfunction
   task automatic chk(input string nm, input logic [19:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic results();
      if (n_fail == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ---------------------------------
   // mode, load, plot, then check
   // ---------------------------------
   initial begin
      {rst_n, mode_wr, colour_load, plot_op, read_pixel_flush_op, x_wr, y_wr, height_select_lo, height_select_hi} = '0;
      {mode_wdata, colour_src, screen_base_reg, bitplane_index, colour_depth, x_wdata, y_wdata, rd_addr} = '0;
      n_fail = 0;
      n_checks = 0;
      rs = 32'h0000_0018;
      lat = LATCH_RESET;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 400; i++) begin
         rs = xs(rs);
         md = i < 32 ? 5'(i) : rs[4:0];
         d = rs[6:5] == 2'h2 ? 2'h3 : rs[6:5];
         @(posedge mclk);
         // flushing with the mode change keeps cached pixels out of the new layout
         read_pixel_flush_op <= 1'b1;
         {mode_wr, x_wr, y_wr, mode_wdata, colour_depth} <= {3'h7, md, d};
         {x_wdata, y_wdata} <= rs ^ {rs[7:0], rs[31:8]};
         {height_select_hi, height_select_lo, screen_base_reg, bitplane_index} <= {rs[12:11], rs[20:13], rs[23:21]};
         rs = xs(rs);
         @(posedge mclk);
         {read_pixel_flush_op, mode_wr, x_wr, y_wr} <= '0;
         colour_load <= 1'b1;
         colour_src <= i < 64 ? {rs[3] ? 4'hf : 4'h0, 4'h0} : rs[7:0];
         @(negedge mclk);
         chk("flush", 20'h0_0002, 20'({plot_out.valid, plot_out.write}));
         chk("mode", 20'(md), 20'(plot_colour_mode));
         @(posedge mclk);
         colour_load <= 1'b0;
         plot_op <= 1'b1;
         if (md[3] && d == 2'h3)
            lat = {lat[7:4], md[2] ? colour_src[7:4] : colour_src[3:0]};
         else
            lat = md[2] ? {4'h0, colour_src[7:4]} : colour_src;
         @(posedge mclk);
         plot_op <= 1'b0;
         @(negedge mclk);
         wr = md[0] || (md[3] ? lat[3:0] != 4'h0 : lat != 8'h00);
         px = md[1] && d != 2'h3 ? {4'h0, x_wdata[0] ^ y_wdata[0] ? lat[7:4] : lat[3:0]} : lat;
         ea = f_ad(f_cn(x_wdata[7:0], y_wdata[7:0], md[4], {height_select_hi, height_select_lo}), y_wdata[2:0],
            bitplane_index, d);
         chk("latch", 20'(lat), 20'(colour_latch));
         chk("x", 20'(x_wdata + 16'h0001), 20'(x_coord_reg));
         chk("write", 20'(wr), 20'(plot_out.write));
         chk("index", 20'(f_cn(x_wdata[7:0], y_wdata[7:0], md[4], {height_select_hi, height_select_lo})),
            20'(plot_out.char_index));
         chk("addr", ea, plot_out.addr);
         chk("pixel", 20'(px), 20'(plot_out.pixel));
         chk("pixel_lo", 20'(px[3:0]), 20'(plot_out.pixel_lo));
         chk("y", 20'(y_wdata), 20'(y_coord_reg));
         // the model stores on the edge after the plot result appears
         rd_addr = ea;
         @(negedge mclk);
         if (wr)
            chk("ram", 20'(px), 20'(rd_data));
      end
      results();
   end
endmodule
`default_nettype wire
